// file: sram_ctrl_pkg.sv
package sram_ctrl_pkg;
  // Address and lane geometry
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int SEED_W = 2;
  // Burst counter reset value
  localparam logic [SEED_W-1:0] SEED_RST = 2'h0;
  // Burst ordering select level
  localparam logic ORDER_INTERLEAVED = 1'h1;
  // Access kinds
  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_READ = 3'h2,
    ACC_WRITE = 3'h4
  } access_t;
endpackage

// file: burst_if.sv
`timescale 1ns/1ps
// Carries the burst counter controls between the top and the counter
interface burst_if;
  import sram_ctrl_pkg::*;
  logic load; // Seed the counter
  logic step; // Advance one beat
  logic interleaved; // Ordering mode
  logic [SEED_W-1:0] seed; // Starting low address bits
  logic [SEED_W-1:0] low_addr; // Current low address bits
  modport ctrl (output load, output step, output interleaved, output seed, input low_addr);
  modport cnt (input load, input step, input interleaved, input seed, output low_addr);
endinterface

// file: burst_counter.sv
`timescale 1ns/1ps
// Two-bit burst counter, linear or interleaved order
module burst_counter
  import sram_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  burst_if.cnt bus
);
  // Counter state
  typedef struct packed {
    logic [SEED_W-1:0] base; // Seed captured at load
    logic [SEED_W-1:0] beat; // Beats advanced since load
  } cnt_state_t;
  cnt_state_t state_reg;
  cnt_state_t state_next;

  // Next state: load seeds, step advances
  always_comb begin
    state_next = state_reg;
    if (bus.load) begin
      state_next.base = bus.seed;
      state_next.beat = SEED_RST;
    end else if (bus.step) begin
      state_next.beat = state_reg.beat + 2'h1;
    end
  end

  // Register state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Interleaved xors the beat, linear adds it
  assign bus.low_addr = bus.interleaved ? (state_reg.base ^ state_reg.beat)
                                        : SEED_W'(state_reg.base + state_reg.beat);
endmodule // burst_counter

// file: sync_sram_addr_write_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Capture address on strobe with chip selected
// - Seed burst counter from low address bits
// - Register all synchronous inputs on clock rise
// - Advance burst counter when advance is low
// - Lane select low plus qualifier writes lane
// - Global write low writes every lane
// - Primary select active low, combined with others
// - Processor strobe ignored when primary select high
// - Chip selects looked at only on address load
// - Both strobes low: processor strobe wins
// - Second select high-active, third low-active
// - Ordering input: high interleaved, low linear
module sync_sram_addr_write_ctrl
  import sram_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_in, // Upper address inputs
  input wire logic burst_seed_bit0, // Low address bit 0
  input wire logic burst_seed_bit1, // Low address bit 1
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] data_in, // Write data
  input wire logic processor_addr_strobe, // Active low
  input wire logic controller_addr_strobe, // Active low
  input wire logic burst_advance, // Active low
  input wire logic byte_write_qualifier, // Active low
  input wire logic lane_a_write_select, // Active low
  input wire logic lane_b_write_select, // Active low
  input wire logic lane_c_write_select, // Active low
  input wire logic lane_d_write_select, // Active low
  input wire logic all_lanes_write, // Active low
  input wire logic primary_chip_select_n,
  input wire logic second_chip_select,
  input wire logic third_chip_select_n,
  input wire logic burst_order, // High interleaved, low linear
  output logic [sram_ctrl_pkg::ADDR_W-1:0] mem_addr, // Full access address
  output logic [sram_ctrl_pkg::DATA_W-1:0] mem_wdata, // Registered write data
  output logic [sram_ctrl_pkg::LANES-1:0] mem_lane_we, // Lane write strobes
  output logic mem_read, // Read access this cycle
  output logic mem_selected // Device selected
);
  import sram_ctrl_pkg::*;

  // Is the device selected by the three chip selects
  function automatic logic chip_selected(input logic cs1_n, input logic cs2, input logic cs3_n);
    chip_selected = !cs1_n && cs2 && !cs3_n;
  endfunction

  // Sampled inputs, one cycle behind the pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SEED_W-1:0] seed;
    logic [DATA_W-1:0] data;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic adv_n;
    logic bwq_n;
    logic [LANES-1:0] lane_n;
    logic gw_n;
    logic cs1_n;
    logic cs2;
    logic cs3_n;
    logic order;
  } in_t;

  // Whole module state
  typedef struct packed {
    in_t smp; // Input sample registers
    logic [ADDR_W-1:0] addr_hold; // Captured external address
    logic selected; // Selection held from last load
    logic in_burst; // Burst in progress
    access_t acc; // Kind of current access
    logic [ADDR_W-1:0] addr_out;
    logic [DATA_W-1:0] wdata_out;
    logic [LANES-1:0] we_out;
    logic read_out;
    logic sel_out;
  } state_t;

  state_t state_reg;
  state_t state_next;
  burst_if bif ();

  // Working signals of the decode
  logic ps_take; // Processor strobe recognised
  logic cs_take; // Controller strobe recognised
  logic load; // New external address loaded
  logic [LANES-1:0] lane_we; // Lane write decode

  // Burst counter seeded from the sampled low bits
  burst_counter u_counter (
    .clk(clk),
    .reset(reset),
    .bus(bif)
  );

  // Counter controls. The counter is seeded only by a load that selects
  // the device: a deselected strobe captures no address, so it must not
  // disturb the low bits that the last burst left on the address output.
  // The selection test is the same function used for the held selection.
  assign bif.load = load && chip_selected(state_reg.smp.cs1_n, state_reg.smp.cs2,
                                          state_reg.smp.cs3_n);
  // Advance only inside a burst, never on an edge that loads a new address
  assign bif.step = !load && state_reg.in_burst && !state_reg.smp.adv_n;
  // Ordering pin is sampled like every other input
  assign bif.interleaved = (state_reg.smp.order == ORDER_INTERLEAVED);
  // Seed comes from the two sampled low address pins
  assign bif.seed = state_reg.smp.seed;

  // Strobe decode on the sampled inputs
  always_comb begin
    // Processor strobe needs the primary select low; the controller strobe
    // counts only when the processor strobe is not taken
    ps_take = !state_reg.smp.processor_addr_strobe_n && !state_reg.smp.cs1_n;
    cs_take = !state_reg.smp.controller_addr_strobe_n && (state_reg.smp.processor_addr_strobe_n || state_reg.smp.cs1_n);
    load = ps_take || cs_take;
    // Global write overrides the qualifier and every lane select
    if (!state_reg.smp.gw_n) begin
      lane_we = '1;
    end else if (!state_reg.smp.bwq_n) begin
      lane_we = ~state_reg.smp.lane_n;
    end else begin
      lane_we = '0;
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    // Register every pin each edge
    state_next.smp.addr = addr_in;
    state_next.smp.seed = {burst_seed_bit1, burst_seed_bit0};
    state_next.smp.data = data_in;
    state_next.smp.processor_addr_strobe_n = processor_addr_strobe;
    state_next.smp.controller_addr_strobe_n = controller_addr_strobe;
    state_next.smp.adv_n = burst_advance;
    state_next.smp.bwq_n = byte_write_qualifier;
    state_next.smp.lane_n = {lane_d_write_select, lane_c_write_select,
                             lane_b_write_select, lane_a_write_select};
    state_next.smp.gw_n = all_lanes_write;
    state_next.smp.cs1_n = primary_chip_select_n;
    state_next.smp.cs2 = second_chip_select;
    state_next.smp.cs3_n = third_chip_select_n;
    state_next.smp.order = burst_order;
    // Access strobes are one-cycle pulses unless a beat below raises them
    state_next.we_out = '0;
    state_next.read_out = 1'h0;
    if (load) begin
      // Selects only looked at when an address loads
      state_next.selected = chip_selected(state_reg.smp.cs1_n, state_reg.smp.cs2,
                                          state_reg.smp.cs3_n);
      if (state_next.selected) begin
        // Selected: take the upper address and start a burst
        state_next.addr_hold = state_reg.smp.addr;
        state_next.in_burst = 1'h1;
        if (lane_we != '0) begin
          // Some lane written, globally or through a qualified select
          state_next.acc = ACC_WRITE;
          state_next.we_out = lane_we;
        end else begin
          // Nothing written, so the access is a read
          state_next.acc = ACC_READ;
          state_next.read_out = 1'h1;
        end
      end else begin
        // Deselected: no access, and a running burst ends
        state_next.in_burst = 1'h0;
        state_next.acc = ACC_IDLE;
      end
    end else if (state_reg.in_burst && !state_reg.smp.adv_n) begin
      // Continue the burst with the held selection
      if (state_reg.acc == ACC_WRITE) begin
        // Write beats take the lane decode sampled on this beat
        state_next.we_out = lane_we;
      end else begin
        // Read beats repeat the read pulse
        state_next.read_out = 1'h1;
      end
    end
    // Selection output stands until the next load
    state_next.sel_out = state_next.selected;
    // Write data leaves two edges after the pins, beside its lane strobes
    state_next.wdata_out = state_reg.smp.data;
    // Upper bits from the captured address, low bits from the counter
    state_next.addr_out = {state_next.addr_hold[ADDR_W-1:SEED_W], bif.low_addr};
  end

  // Address output straight from its flip-flops
  always_comb begin
    mem_addr = state_reg.addr_out;
  end

  // Register state. Reset parks every sampled strobe, write and select at
  // its inactive level, so the first edge after release cannot decode a
  // load from reset values.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.smp.processor_addr_strobe_n <= 1'h1;
      state_reg.smp.controller_addr_strobe_n <= 1'h1;
      state_reg.smp.adv_n <= 1'h1;
      state_reg.smp.bwq_n <= 1'h1;
      state_reg.smp.gw_n <= 1'h1;
      state_reg.smp.lane_n <= '1;
      state_reg.smp.cs1_n <= 1'h1;
      state_reg.smp.cs3_n <= 1'h1;
      state_reg.acc <= ACC_IDLE;
    end else begin
      // Whole state moves together
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign mem_wdata = state_reg.wdata_out;
  assign mem_lane_we = state_reg.we_out;
  assign mem_read = state_reg.read_out;
  assign mem_selected = state_reg.sel_out;
endmodule // sync_sram_addr_write_ctrl

// file: ctrl_monitor.sv
`timescale 1ns/1ps
// Expectations trail the pins by two edges: one to sample them, one to decode
module ctrl_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic burst_seed_bit0,
  input wire logic burst_seed_bit1,
  input wire logic processor_addr_strobe,
  input wire logic controller_addr_strobe,
  input wire logic byte_write_qualifier,
  input wire logic lane_a_write_select,
  input wire logic lane_b_write_select,
  input wire logic lane_c_write_select,
  input wire logic lane_d_write_select,
  input wire logic all_lanes_write,
  input wire logic primary_chip_select_n,
  input wire logic second_chip_select,
  input wire logic third_chip_select_n,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [sram_ctrl_pkg::LANES-1:0] mem_lane_we,
  input wire logic mem_read,
  input wire logic mem_selected
);
  import sram_ctrl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] up_reg; // Edges since reset; gates out stale history
  logic [12:0] d1_reg; // Pins one edge back
  logic [12:0] d2_reg; // Pins two edges back
  wire ld = up_reg[1] & (~d2_reg[12] & ~d2_reg[10] | ~d2_reg[11]); // Address load
  wire sel = ~d2_reg[10] & d2_reg[9] & ~d2_reg[8]; // Every select active
  wire wr = ~d2_reg[7] | ~d2_reg[6] & ~&d2_reg[5:2]; // Some lane written
  // Pin history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      up_reg <= 2'h0;
      d1_reg <= 13'h0;
      d2_reg <= 13'h0;
    end else begin
      up_reg <= up_reg + {1'h0, ~&up_reg};
      d1_reg <= {processor_addr_strobe, controller_addr_strobe, primary_chip_select_n,
        second_chip_select, third_chip_select_n, all_lanes_write, byte_write_qualifier,
        lane_d_write_select, lane_c_write_select, lane_b_write_select, lane_a_write_select,
        burst_seed_bit1, burst_seed_bit0};
      d2_reg <= d1_reg;
    end
  end
  // Upper address now, seeded low bits one edge later
  sequence take_s;
    mem_addr[ADDR_W-1:2] == $past(addr_in[ADDR_W-1:2], 2) ##1 mem_addr[1:0] == $past(d2_reg[1:0]);
  endsequence
  sel_on_load_a: assert property (ld |-> mem_selected == sel) else $error("bad select");
  sel_hold_a: assert property (
    up_reg[1] && !ld |-> $stable(mem_selected)) else $error("bad hold");
  all_lanes_a: assert property (
    ld && sel && !d2_reg[7] |-> mem_lane_we == 4'hF) else $error("bad all");
  lane_pick_a: assert property (
    ld && sel && d2_reg[7] && !d2_reg[6] |-> mem_lane_we == ~d2_reg[5:2])
    else $error("bad lanes");
  read_beat_a: assert property (ld && sel |-> mem_read == !wr) else $error("bad read");
  no_access_a: assert property (
    ld && !sel |-> !mem_read && mem_lane_we == 4'h0) else $error("bad idle");
  addr_take_a: assert property (ld && sel |-> take_s) else $error("bad address");
  strobe_ign_a: assert property (
    up_reg[1] && !d2_reg[12] && d2_reg[10] && d2_reg[11]
    |-> mem_addr[ADDR_W-1:2] == $past(mem_addr[ADDR_W-1:2])) else $error("bad ignore");
endmodule // ctrl_monitor

// file: host_model.sv
`timescale 1ns/1ps
// Host side of the bus: all pins change just after the falling edge
module host_model (
  input wire logic clk,
  output logic [12:0] pins,
  output logic adv_n,
  output logic [sram_ctrl_pkg::ADDR_W-1:0] addr,
  output logic [sram_ctrl_pkg::DATA_W-1:0] data
);
  import sram_ctrl_pkg::*;
  // Idle: strobes and writes released high
  initial begin
    pins = 13'h1FFF;
    adv_n = 1'b1;
    addr = 18'h0;
    data = 36'h0;
  end
  // One bus cycle, valid across the next rising edge
  task automatic beat(input logic [12:0] v, input logic a, input logic [17:0] ad);
    @(negedge clk);
    pins <= v;
    adv_n <= a;
    addr <= ad;
    data <= {ad, ~ad}; // Address in the upper half, its inverse in the lower half
  endtask
endmodule // host_model

// file: sync_sram_addr_write_ctrl_tb_top.sv
`timescale 1ns/1ps
// Table rows, one burst per ordering mode, then a mid-run reset
module sync_sram_addr_write_ctrl_tb_top;
  import sram_ctrl_pkg::*;
  logic clk;
  logic reset;
  logic order; // Burst ordering pin
  logic adv_n;
  logic [12:0] pins; // Strobes, selects, writes, seed
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] mem_wdata;
  logic [LANES-1:0] mem_lane_we;
  logic mem_read;
  logic mem_selected;
  int errors;
  int cmp_count;
  // Rows: pins, then lane strobes, read, selected
  logic [18:0] rows [9] = '{19'h2BF03, 19'h48A7D, 19'h2AA95, 19'h2BA83, 19'h3BF01, 19'h43F00,
    19'h4FF00, 19'h0BF03, 19'h5BF00};
  host_model host (.clk, .pins, .adv_n, .addr, .data);
  sync_sram_addr_write_ctrl uut (.clk, .reset, .addr_in(addr), .burst_seed_bit0(pins[0]),
    .burst_seed_bit1(pins[1]), .data_in(data), .processor_addr_strobe(pins[12]),
    .controller_addr_strobe(pins[11]), .burst_advance(adv_n), .byte_write_qualifier(pins[6]),
    .lane_a_write_select(pins[2]), .lane_b_write_select(pins[3]),
    .lane_c_write_select(pins[4]), .lane_d_write_select(pins[5]), .all_lanes_write(pins[7]),
    .primary_chip_select_n(pins[10]), .second_chip_select(pins[9]),
    .third_chip_select_n(pins[8]), .burst_order(order), .mem_addr, .mem_wdata, .mem_lane_we,
    .mem_read, .mem_selected);
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog: the run needs under 80 cycles
  initial begin
    #5000;
    errors++;
    report_and_stop();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    order = 1'b0;
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      host.beat(rows[i][18:6], 1'b1, 18'(i * 4 + 4));
      host.beat(13'h1FFF, 1'b1, 18'h0);
      @(negedge clk);
      chk("lanes", 18'(rows[i][5:2]), 18'(mem_lane_we));
      chk("read", 18'(rows[i][1]), 18'(mem_read));
      chk("selected", 18'(rows[i][0]), 18'(mem_selected));
      chk("write data", 18'(i * 4 + 4), mem_wdata[35:18]);
      $display("row %0d done", i);
    end
    // Seed 1, three advances: linear ends at 0, interleaved at 2
    for (int m = 0; m < 2; m++) begin
      order = m[0];
      host.beat(13'h0AFD, 1'b1, 18'h4);
      repeat (3) host.beat(13'h1FFF, 1'b0, 18'h0);
      host.beat(13'h1FFF, 1'b1, 18'h0);
      repeat (3) @(negedge clk);
      chk("burst", m[0] ? 18'h6 : 18'h4, mem_addr);
      $display("burst order %0d done", m);
    end
    reset = 1'b1;
    @(negedge clk);
    chk("reset address", 18'h0, mem_addr);
    chk("reset flags", 18'h0, 18'({mem_read, mem_selected, mem_lane_we}));
    chk("reset data", 18'h0, mem_wdata[17:0]);
    reset = 1'h0;
    // Recovery: a read right after release behaves like the first one
    host.beat(13'h0AFD, 1'h1, 18'h8);
    host.beat(13'h1FFF, 1'h1, 18'h0);
    @(negedge clk);
    chk("after reset", 18'h3, 18'({mem_read, mem_selected}));
    $display("reset done");
    report_and_stop();
  end
endmodule // sync_sram_addr_write_ctrl_tb_top
bind sync_sram_addr_write_ctrl ctrl_monitor mon (.clk, .reset, .addr_in, .burst_seed_bit0,
  .burst_seed_bit1, .processor_addr_strobe, .controller_addr_strobe, .byte_write_qualifier,
  .lane_a_write_select, .lane_b_write_select, .lane_c_write_select, .lane_d_write_select,
  .all_lanes_write, .primary_chip_select_n, .second_chip_select, .third_chip_select_n,
  .mem_addr, .mem_lane_we, .mem_read, .mem_selected);
